// ==== bench/pfcs_chk_sva.sv ====
// Purpose: Port assertions for pfcs_top
// Assumes: Two-flop flag sync, registered outputs
// Notes: Bound at the foot of this file
`timescale 1ns/10ps
module pfcs_chk
    import pfcs_pkg::*;
(
    // Clock, reset, flags
    input wire logic clk_sys,
    input wire logic rstn,
    input wire pfcs_cmp_t cmp_async,
    // Outputs
    input wire logic gate_run_r,
    input wire logic cycle_start_r,
    input wire logic node_clamp_r,
    input wire logic [WORD_W-1:0] amp_word_r,
    input wire logic bulk_good_flag_r,
    input wire logic softstart_r,
    input wire logic irq_r
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // --
    // Properties
    // --
    property p_start; $rose(gate_run_r) |-> $past(cmp_async.supply_above_on, 3); endproperty
    a_start: assert property (p_start) else $error("start without supply");
    property p_off; cmp_async.supply_below_off [*3] |=> !gate_run_r; endproperty
    a_off: assert property (p_off) else $error("gate in off");
    property p_stby;
        (!cmp_async.bulk_above_min || !cmp_async.enable_above_min) [*3] |=> !gate_run_r;
    endproperty
    a_stby: assert property (p_stby) else $error("gate in standby");
    property p_ramp;
        softstart_r && $past(softstart_r) |-> amp_word_r - $past(amp_word_r) <= 9'h1;
    endproperty
    a_ramp: assert property (p_ramp) else $error("ramp step");
    property p_bg; $rose(bulk_good_flag_r) |-> gate_run_r && !softstart_r; endproperty
    a_bg: assert property (p_bg) else $error("bulk good rise");
    property p_max; amp_word_r <= WORD_MAX; endproperty
    a_max: assert property (p_max) else $error("word above max");
    property p_force; node_clamp_r |-> !gate_run_r && !bulk_good_flag_r; endproperty
    a_force: assert property (p_force) else $error("force with gate");
    property p_thl; cmp_async.bulk_below_thl [*3] |=> !bulk_good_flag_r; endproperty
    a_thl: assert property (p_thl) else $error("bulk good held");
    property p_cyc; cycle_start_r |-> gate_run_r || $past(gate_run_r); endproperty
    a_cyc: assert property (p_cyc) else $error("cycle while stopped");
    c_bg: cover property ($rose(bulk_good_flag_r));
    c_force: cover property ($rose(node_clamp_r));
    c_irq: cover property ($rose(irq_r));
endmodule // pfcs_chk

bind pfcs_top pfcs_chk u_chk (.*);

// ==== bench/pfcs_stage_model.sv ====
// Purpose: Analog stage and sync source beside pfcs_top
// Assumes: Pin levels in millivolts, set by the bench
// Notes: First-order modulator on the bulk level
`timescale 1ns/10ps
module pfcs_stage_model
    import pfcs_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Pin levels
    input wire logic [15:0] supply_mv,
    input wire logic [15:0] bulk_mv,
    input wire logic [15:0] brn_mv,
    input wire logic [15:0] en_mv,
    input wire logic [15:0] thl_mv,
    // Sync source
    input wire logic sync_on,
    input wire logic pulse_en,
    input wire logic [7:0] sync_per,
    // Flags
    output pfcs_cmp_t cmp
);
    logic [15:0] acc_r = 16'h0;
    logic [7:0] ph_r = 8'h0;
    logic [16:0] sum;
    assign sum = {1'b0, acc_r} + {1'b0, bulk_mv};
    // Ones density follows bulk level over a 2.5 V span
    always_ff @(posedge clk_sys)
    begin
        acc_r <= (sum >= 17'h9c4) ? 16'(sum - 17'h9c4) : sum[15:0];
        ph_r <= (pulse_en && ph_r < sync_per - 8'h1) ? ph_r + 8'h1 : 8'h0;
    end
    assign cmp = '{supply_mv > 16'h2ee0, supply_mv < 16'h2af8, bulk_mv > 16'h1f4,
        brn_mv > 16'h4e2, en_mv > 16'h1f4, bulk_mv < thl_mv, sync_on,
        pulse_en && ph_r < 8'h2, sum >= 17'h9c4};
endmodule // pfcs_stage_model

// ==== bench/tb_pfc_control_sequencer_sync.sv ====
// Purpose: Self-checking bench for pfcs_top
// Assumes: Shortened sample and oscillator periods
// Notes: Stage model drives all comparator flags
`timescale 1ns/10ps
module tb_pfc_control_sequencer_sync;
    import pfcs_pkg::*;
    localparam int SC = 64;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    pfcs_cmp_t cmp_async;
    logic gate_run_r, cycle_start_r, node_clamp_r, bulk_good_flag_r, softstart_r, irq_r;
    logic [WORD_W-1:0] amp_word_r;
    logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0, sync_per = 8'h64;
    logic [31:0] s_wdata = 32'h0, s_rdata, rd;
    logic [3:0] s_wstrb = 4'hf;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b1, s_arvalid = 1'b0;
    logic s_rready = 1'b1, sync_on = 1'b0, pulse_en = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp, rs;
    logic [15:0] supply_mv = 16'h0, bulk_mv = 16'h0, brn_mv = 16'h0, en_mv = 16'h0, thl_mv = 16'h0;
    int error_cnt = 0, total_checks = 0, cs_cnt = 0, c0;

    pfcs_top #(.SAMPLE_CYCLES(SC), .OSC_CYCLES(20)) u_dut (.*);
    pfcs_stage_model u_stage (.clk_sys, .supply_mv, .bulk_mv, .brn_mv, .en_mv, .thl_mv,
        .sync_on, .pulse_en, .sync_per, .cmp(cmp_async));

    initial
        forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (cycle_start_r === 1'b1)
            cs_cnt <= cs_cnt + 1;
    initial
    begin
        #(60000 * 50);
        error_cnt++;
        stop_test();
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_awready)
                s_awvalid <= 1'b0;
            if (s_wready)
                s_wvalid <= 1'b0;
        end while (s_bvalid !== 1'b1);
        r = s_bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_arready)
                s_arvalid <= 1'b0;
        end while (s_rvalid !== 1'b1);
        d = s_rdata;
        r = s_rresp;
    endtask
    // --
    // Scenarios
    // --
    task automatic t_regs;
        axi_rd(REG_GAIN, rd, rs);
        chk(rd, GAIN_RST, "gain");
        axi_rd(8'h18, rd, rs);
        chk({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "hole rd");
        axi_wr(8'h18, 32'h1, rs);
        chk(rs, RESP_SLVERR, "hole wr");
    endtask
    task automatic t_start;
        supply_mv <= 16'h30d4;
        brn_mv <= 16'h05dc;
        en_mv <= 16'h07d0;
        thl_mv <= 16'h03e8;
        bulk_mv <= 16'h012c;
        axi_wr(REG_TARGET, 32'h1fff, rs);
        axi_wr(REG_IRQ_MASK, 32'h4, rs);
        cyc(20);
        chk(gate_run_r, 1'b0, "low bulk");
        bulk_mv <= 16'h08ca;
        cyc(6);
        chk({gate_run_r, softstart_r, node_clamp_r}, 3'b110, "start");
        cyc(30 * SC);
        chk(softstart_r && amp_word_r > 9'h19 && amp_word_r < 9'h21, 1'b1, "ramp");
        axi_rd(REG_STATUS, rd, rs);
        axi_wr(REG_TARGET, {19'h0, rd[29:17]}, rs);
        for (int i = 0; i < 4 * SC && bulk_good_flag_r !== 1'b1; i++)
            @(posedge clk_sys);
        chk({bulk_good_flag_r, softstart_r, gate_run_r}, 3'b101, "good");
        cyc(2);
        chk(irq_r, 1'b1, "irq");
        axi_wr(REG_IRQ_STAT, 32'h4, rs);
        cyc(2);
        chk(irq_r, 1'b0, "irq clr");
    endtask
    task automatic t_sync;
        sync_on <= 1'b1;
        pulse_en <= 1'b1;
        cyc(450);
        axi_rd(REG_STATUS, rd, rs);
        chk(rd[ST_LOCK_BIT], 1'b0, "early lock");
        cyc(200);
        axi_rd(REG_STATUS, rd, rs);
        chk(rd[ST_LOCK_BIT], 1'b1, "lock");
        c0 = cs_cnt;
        cyc(100);
        chk(cs_cnt - c0, 1, "ext rate");
        pulse_en <= 1'b0;
        cyc(2300);
        axi_rd(REG_STATUS, rd, rs);
        chk(rd[ST_LOCK_BIT], 1'b0, "unlock");
        c0 = cs_cnt;
        cyc(100);
        chk(cs_cnt - c0, 5, "int rate");
        sync_on <= 1'b0;
    endtask
    task automatic t_stby;
        thl_mv <= 16'h0960;
        cyc(6);
        chk({bulk_good_flag_r, gate_run_r}, 2'b01, "good low");
        thl_mv <= 16'h03e8;
        en_mv <= 16'h012c;
        cyc(6);
        chk({node_clamp_r, gate_run_r, bulk_good_flag_r}, 3'b100, "stby");
        en_mv <= 16'h07d0;
        cyc(6);
        chk({softstart_r, amp_word_r < 9'h2}, 2'b11, "restart");
    endtask
    task automatic t_off;
        supply_mv <= 16'h2904;
        cyc(6);
        axi_rd(REG_STATUS, rd, rs);
        chk({gate_run_r, rd[1:0]}, 3'b000, "off");
        supply_mv <= 16'h30d4;
        cyc(6);
        chk(gate_run_r, 1'b1, "on again");
    endtask
    task automatic stop_test;
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        cyc(2);
        t_regs();
        t_start();
        t_sync();
        t_stby();
        t_off();
        stop_test();
    end
endmodule // tb_pfc_control_sequencer_sync

// ==== pkg/pfcs_pkg.sv ====
// Purpose: Shared constants and types for the PFC control sequencer
// Assumes: 20 MHz system clock, AXI4-Lite register access
// Notes: Comparator flags come from analog pins, asynchronous to clk_sys
package pfcs_pkg;

    // --
    // Clock and timing
    // --
    localparam int CLK_HZ = 20_000_000;
    localparam int SAMPLE_HZ = 3550;
    localparam int SAMPLE_CYC = (CLK_HZ + SAMPLE_HZ / 2) / SAMPLE_HZ;
    localparam int SYNC_TMO_NS = 108_000;
    localparam int SYNC_TMO_CYC = SYNC_TMO_NS / (1_000_000_000 / CLK_HZ);
    localparam int FSW_HZ = 65_000;
    localparam int OSC_CYC = CLK_HZ / FSW_HZ;
    localparam int SYNC_LOCK_PULSES = 6;
    localparam int NOTCH_DLY = 18;

    // --
    // Voltage loop
    // --
    localparam int SMP_W = 13;
    localparam int WORD_W = 9;
    localparam logic [WORD_W-1:0] WORD_MAX = 9'h100;
    localparam logic [WORD_W-1:0] SS_INIT = 9'h000;
    localparam int BG_PCT = 95;
    localparam int INT_FRAC = 8;

    // --
    // Register map and reset values
    // --
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_GAIN = 8'h10;
    localparam logic [7:0] REG_TARGET = 8'h14;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] GAIN_RST = 32'h0000_0410;
    localparam logic [31:0] TARGET_RST = 32'h0000_0b00;
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_BG_BIT = 2;
    localparam int ST_LOCK_BIT = 3;
    localparam int ST_WORD_LSB = 8;
    localparam int ST_SMP_LSB = 17;
    localparam int IRQ_W = 6;
    localparam int IRQ_OFF = 0;
    localparam int IRQ_STBY = 1;
    localparam int IRQ_BG_RISE = 2;
    localparam int IRQ_BG_FALL = 3;
    localparam int IRQ_LOCK = 4;
    localparam int IRQ_UNLOCK = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // --
    // Types
    // --
    typedef enum logic [1:0] {ST_OFF, ST_STANDBY, ST_SOFTSTART, ST_RUN} pfcs_state_t;

    typedef struct packed {
        logic supply_above_on;
        logic supply_below_off;
        logic bulk_above_min;
        logic brownout_above_on;
        logic enable_above_min;
        logic bulk_below_thl;
        logic rate_above_sync;
        logic ext_pulse;
        logic sd_bit;
    } pfcs_cmp_t;

    localparam int CMP_W = $bits(pfcs_cmp_t);

endpackage

// ==== verilog/pfcs_sync2.sv ====
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels
// Assumes: Inputs are slow levels relative to clk_sys
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module pfcs_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Levels
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] q_sync
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= '0;
            q_sync <= '0;
        end
        else
        begin
            meta_r <= d_async;
            q_sync <= meta_r;
        end
    end

endmodule // pfcs_sync2

// ==== verilog/pfcs_top.sv ====
// Purpose: Sequencing, sync selection and digital voltage loop of a PFC core
// Assumes: Analog thresholds arrive as comparator flags
// Notes: Registers over AXI4-Lite; one level interrupt
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - Start only with supply, bulk, brownout good
// - Supply below off level forces off state
// - Low bulk or enable pin gives standby
// - Soft-start ramps word while below 95%
// - At 95% release ramp, set bulk good
// - Lock to external pulses after six
// - External rising edge ends each cycle
// - Pulse gap over 108us reverts oscillator
// - Decimate sigma-delta stream at 3.55 kHz
// - Notch out twice-line ripple by comb
// - PI compensation drives amplitude word
// - Compensator word saturates at 256
// - Standby forces compensation node high
// - Leaving standby restarts with soft-start
// - Bulk good drops below THL threshold
module pfcs_top
    import pfcs_pkg::*;
#(
    parameter int SAMPLE_CYCLES = SAMPLE_CYC,
    parameter int OSC_CYCLES = OSC_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Comparator flags from pins
    input wire pfcs_cmp_t cmp_async,
    // Power stage controls
    output logic gate_run_r,
    output logic cycle_start_r,
    output logic node_clamp_r,
    output logic [WORD_W-1:0] amp_word_r,
    output logic bulk_good_flag_r,
    output logic softstart_r,
    output logic irq_r,
    // AXI4-Lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);

    // --
    // Input synchronisers
    // --
    pfcs_cmp_t cmp;
    pfcs_sync2 #(.W(CMP_W)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .d_async(cmp_async),
        .q_sync(cmp)
    );

    logic [31:0] ctrl_r;
    logic [31:0] gain_r;
    logic [31:0] target_r;
    logic [IRQ_W-1:0] irq_stat_r;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_ev;

    // --
    // Operating state
    // --
    pfcs_state_t state_r;
    pfcs_state_t state_nxt;
    logic stby_cond;
    logic ss_done;

    assign stby_cond = !cmp.bulk_above_min || !cmp.enable_above_min || !ctrl_r[CTRL_RUN_BIT];

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF:
                if (cmp.supply_above_on && cmp.bulk_above_min && cmp.brownout_above_on
                    && cmp.enable_above_min && ctrl_r[CTRL_RUN_BIT])
                    state_nxt = ST_SOFTSTART;
            ST_STANDBY:
                if (!stby_cond)
                    state_nxt = ST_SOFTSTART;
            ST_SOFTSTART:
                if (ss_done)
                    state_nxt = ST_RUN;
            ST_RUN:
                state_nxt = ST_RUN;
        endcase
        if (state_r != ST_OFF && stby_cond)
            state_nxt = ST_STANDBY;
        if (cmp.supply_below_off)
            state_nxt = ST_OFF;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            state_r <= ST_OFF;
        else
            state_r <= state_nxt;
    end

    // Drive permission and standby clamp
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            gate_run_r <= 1'b0;
            node_clamp_r <= 1'b0;
            softstart_r <= 1'b0;
        end
        else
        begin
            gate_run_r <= (state_nxt == ST_SOFTSTART) || (state_nxt == ST_RUN);
            node_clamp_r <= (state_nxt == ST_STANDBY);
            softstart_r <= (state_nxt == ST_SOFTSTART);
        end
    end

    // --
    // Oscillator and external sync
    // --
    logic pulse_d_r;
    logic pulse_rise;
    logic [2:0] pulse_cnt_r;
    logic locked_r;
    logic [15:0] gap_cnt_r;
    logic [15:0] osc_cnt_r;
    logic gap_expired;
    logic osc_tick;

    assign pulse_rise = cmp.ext_pulse && !pulse_d_r;
    assign gap_expired = (gap_cnt_r >= 16'(SYNC_TMO_CYC));
    assign osc_tick = (osc_cnt_r >= 16'(OSC_CYCLES - 1));

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            pulse_d_r <= 1'b0;
            pulse_cnt_r <= 3'h0;
            locked_r <= 1'b0;
            gap_cnt_r <= 16'h0000;
        end
        else
        begin
            pulse_d_r <= cmp.ext_pulse;
            if (!cmp.rate_above_sync || gap_expired)
            begin
                pulse_cnt_r <= 3'h0;
                locked_r <= 1'b0;
                gap_cnt_r <= 16'h0000;
            end
            else if (pulse_rise)
            begin
                gap_cnt_r <= 16'h0000;
                if (pulse_cnt_r < 3'(SYNC_LOCK_PULSES))
                    pulse_cnt_r <= pulse_cnt_r + 3'h1;
                if (pulse_cnt_r >= 3'(SYNC_LOCK_PULSES - 1))
                    locked_r <= 1'b1;
            end
            else if (pulse_cnt_r != 3'h0)
                gap_cnt_r <= gap_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_cnt_r <= 16'h0000;
            cycle_start_r <= 1'b0;
        end
        else
        begin
            osc_cnt_r <= (osc_tick || locked_r) ? 16'h0000 : osc_cnt_r + 16'h0001;
            if (locked_r)
                cycle_start_r <= pulse_rise && gate_run_r;
            else
                cycle_start_r <= osc_tick && gate_run_r;
        end
    end

    // --
    // Sigma-delta decimation
    // --
    logic [SMP_W-1:0] win_cnt_r;
    logic [SMP_W-1:0] ones_cnt_r;
    logic [SMP_W-1:0] sample_r;
    logic sample_vld_r;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            win_cnt_r <= '0;
            ones_cnt_r <= '0;
            sample_r <= '0;
            sample_vld_r <= 1'b0;
        end
        else
        begin
            sample_vld_r <= 1'b0;
            if (win_cnt_r >= SMP_W'(SAMPLE_CYCLES - 1))
            begin
                win_cnt_r <= '0;
                ones_cnt_r <= '0;
                sample_r <= ones_cnt_r + SMP_W'(cmp.sd_bit);
                sample_vld_r <= 1'b1;
            end
            else
            begin
                win_cnt_r <= win_cnt_r + 1'b1;
                ones_cnt_r <= ones_cnt_r + SMP_W'(cmp.sd_bit);
            end
        end
    end

    // --
    // Notch filter (half-period comb)
    // --
    logic [SMP_W-1:0] dly_mem [NOTCH_DLY];
    logic [4:0] dly_ptr_r;
    logic [SMP_W-1:0] filt_r;
    logic filt_vld_r;
    logic [SMP_W:0] comb_sum;

    assign comb_sum = {1'b0, sample_r} + {1'b0, dly_mem[dly_ptr_r]};

    always_ff @(posedge clk_sys)
    begin
        if (sample_vld_r)
            dly_mem[dly_ptr_r] <= sample_r;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            dly_ptr_r <= 5'h00;
            filt_r <= '0;
            filt_vld_r <= 1'b0;
        end
        else
        begin
            filt_vld_r <= sample_vld_r;
            if (sample_vld_r)
            begin
                filt_r <= comb_sum[SMP_W:1];
                dly_ptr_r <= (dly_ptr_r == 5'(NOTCH_DLY - 1)) ? 5'h00 : dly_ptr_r + 5'h01;
            end
        end
    end

    // --
    // PI compensator and soft-start
    // --
    localparam int ACC_W = 26;
    localparam logic signed [ACC_W-1:0] ACC_MAX = ACC_W'(int'(WORD_MAX) << INT_FRAC);
    logic signed [ACC_W-1:0] integ_r;
    logic signed [ACC_W-1:0] err;
    logic signed [ACC_W-1:0] integ_sum;
    logic signed [ACC_W-1:0] integ_nxt;
    logic signed [ACC_W-1:0] pi_sum;
    logic [WORD_W-1:0] word_nxt;
    logic [WORD_W-1:0] ramp_r;
    logic [SMP_W+7:0] bg_lhs;
    logic [SMP_W+7:0] bg_rhs;

    assign err = ACC_W'(signed'({1'b0, target_r[SMP_W-1:0]})) - ACC_W'(signed'({1'b0, filt_r}));
    assign integ_sum = integ_r + err * ACC_W'(signed'({1'b0, gain_r[15:8]}));
    assign pi_sum = integ_nxt + err * ACC_W'(signed'({1'b0, gain_r[7:0]}));
    assign bg_lhs = (SMP_W+8)'(filt_r) * (SMP_W+8)'(100);
    assign bg_rhs = (SMP_W+8)'(target_r[SMP_W-1:0]) * (SMP_W+8)'(BG_PCT);
    assign ss_done = filt_vld_r && (bg_lhs >= bg_rhs);

    always_comb
    begin
        if (integ_sum > ACC_MAX)
            integ_nxt = ACC_MAX;
        else if (integ_sum < 0)
            integ_nxt = '0;
        else
            integ_nxt = integ_sum;
        if (pi_sum >= ACC_MAX)
            word_nxt = WORD_MAX;
        else if (pi_sum < 0)
            word_nxt = '0;
        else
            word_nxt = pi_sum[INT_FRAC +: WORD_W];
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ramp_r <= SS_INIT;
            integ_r <= '0;
            amp_word_r <= '0;
        end
        else if (state_r == ST_SOFTSTART)
        begin
            if (filt_vld_r && ramp_r < WORD_MAX)
                ramp_r <= ramp_r + 1'b1;
            integ_r <= ACC_W'(int'(ramp_r) << INT_FRAC);
            amp_word_r <= ramp_r;
        end
        else if (state_r == ST_RUN)
        begin
            if (filt_vld_r)
            begin
                integ_r <= integ_nxt;
                amp_word_r <= word_nxt;
            end
        end
        else
        begin
            ramp_r <= SS_INIT;
            integ_r <= '0;
            amp_word_r <= '0;
        end
    end

    // Bulk good flag
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            bulk_good_flag_r <= 1'b0;
        else if (state_nxt != ST_SOFTSTART && state_nxt != ST_RUN)
            bulk_good_flag_r <= 1'b0;
        else if (cmp.bulk_below_thl)
            bulk_good_flag_r <= 1'b0;
        else if (state_r == ST_SOFTSTART && ss_done)
            bulk_good_flag_r <= 1'b1;
    end

    // --
    // Interrupt events
    // --
    logic bg_d_r;
    logic lock_d_r;
    pfcs_state_t state_d_r;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            bg_d_r <= 1'b0;
            lock_d_r <= 1'b0;
            state_d_r <= ST_OFF;
        end
        else
        begin
            bg_d_r <= bulk_good_flag_r;
            lock_d_r <= locked_r;
            state_d_r <= state_r;
        end
    end

    always_comb
    begin
        irq_ev = '0;
        irq_ev[IRQ_OFF] = (state_r == ST_OFF) && (state_d_r != ST_OFF);
        irq_ev[IRQ_STBY] = (state_r == ST_STANDBY) && (state_d_r != ST_STANDBY);
        irq_ev[IRQ_BG_RISE] = bulk_good_flag_r && !bg_d_r;
        irq_ev[IRQ_BG_FALL] = !bulk_good_flag_r && bg_d_r;
        irq_ev[IRQ_LOCK] = locked_r && !lock_d_r;
        irq_ev[IRQ_UNLOCK] = !locked_r && lock_d_r;
    end

    // --
    // AXI4-Lite slave
    // --
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_write;
    logic [IRQ_W-1:0] w1c;
    logic [31:0] rd_val;
    logic rd_err;

    function automatic logic [31:0] merge(input logic [31:0] old, nw, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    assign do_write = aw_got_r && w_got_r && !s_bvalid;
    assign w1c = (do_write && waddr_r == REG_IRQ_STAT && wstrb_r[0]) ? wdata_r[IRQ_W-1:0] : '0;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_awready && s_awvalid)
            begin
                s_awready <= 1'b0;
                aw_got_r <= 1'b1;
                waddr_r <= s_awaddr;
            end
            else if (!aw_got_r && !s_bvalid)
                s_awready <= 1'b1;
            if (s_wready && s_wvalid)
            begin
                s_wready <= 1'b0;
                w_got_r <= 1'b1;
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end
            else if (!w_got_r && !s_bvalid)
                s_wready <= 1'b1;
            if (do_write)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (waddr_r == REG_CTRL || waddr_r == REG_IRQ_STAT
                            || waddr_r == REG_IRQ_MASK || waddr_r == REG_GAIN
                            || waddr_r == REG_TARGET) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
        end
    end

    // Writable registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_r <= CTRL_RST;
            gain_r <= GAIN_RST;
            target_r <= TARGET_RST;
            irq_mask_r <= '0;
        end
        else if (do_write)
        begin
            if (waddr_r == REG_CTRL)
                ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0001;
            else if (waddr_r == REG_GAIN)
                gain_r <= merge(gain_r, wdata_r, wstrb_r) & 32'h0000_ffff;
            else if (waddr_r == REG_TARGET)
                target_r <= merge(target_r, wdata_r, wstrb_r) & 32'h0000_1fff;
            else if (waddr_r == REG_IRQ_MASK && wstrb_r[0])
                irq_mask_r <= wdata_r[IRQ_W-1:0];
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~w1c) | irq_ev;
            irq_r <= |(((irq_stat_r & ~w1c) | irq_ev) & irq_mask_r);
        end
    end

    // Read decode
    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_araddr == REG_CTRL)
            rd_val = ctrl_r;
        else if (s_araddr == REG_STATUS)
        begin
            rd_val[ST_STATE_LSB +: 2] = state_r;
            rd_val[ST_BG_BIT] = bulk_good_flag_r;
            rd_val[ST_LOCK_BIT] = locked_r;
            rd_val[ST_WORD_LSB +: WORD_W] = amp_word_r;
            rd_val[ST_SMP_LSB +: SMP_W] = filt_r;
        end
        else if (s_araddr == REG_IRQ_STAT)
            rd_val[IRQ_W-1:0] = irq_stat_r;
        else if (s_araddr == REG_IRQ_MASK)
            rd_val[IRQ_W-1:0] = irq_mask_r;
        else if (s_araddr == REG_GAIN)
            rd_val = gain_r;
        else if (s_araddr == REG_TARGET)
            rd_val = target_r;
        else
            rd_err = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= RESP_OKAY;
        end
        else
        begin
            if (s_arready && s_arvalid)
            begin
                s_arready <= 1'b0;
                s_rvalid <= 1'b1;
                s_rdata <= rd_val;
                s_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
            end
            else if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
            else if (!s_rvalid)
                s_arready <= 1'b1;
        end
    end

endmodule // pfcs_top
